// file: tx_dma_pkg.sv
/*
 Shared constants and carrier types of the transmit descriptor DMA.
 Assumes a 32-bit host memory port and an 8-bit Wishbone byte address.
*/
package tx_dma_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CDA = 8'h04;
    localparam logic [7:0] REG_ETT = 8'h08;
    localparam logic [7:0] REG_EVT = 8'h0C;
    localparam logic [7:0] REG_RESULT = 8'h10;

    // Control register bits and the ETT enable bit
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_HALT_BIT = 1;
    localparam int CTRL_RETRY_BIT = 2;
    localparam int CTRL_BUSY_BIT = 3;
    localparam int CTRL_COPY_BIT = 4;
    localparam int CTRL_IDLE_BIT = 5;
    localparam int ETT_EN_BIT = 16;

    // Event bits
    localparam int EVT_QUEUE_EMPTY = 0;
    localparam int EVT_FRAME_DONE = 1;
    localparam int EVT_CHAIN_DONE = 2;
    localparam int EVT_STARVED = 3;

    // Descriptor word 0 and word 1 fields
    localparam int DESC_OWN_BIT = 31;
    localparam int DESC_FINAL_BIT = 16;
    localparam int DESC_IRQ_BIT = 17;
    localparam int DESC_OMIT_BIT = 18;
    localparam int DESC_INDIRECT_BIT = 19;
    localparam int DESC_FORMAT_BIT = 20;
    localparam int FRAG_COUNT_W = 6;

    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] PAIR_STEP = 32'h0000_0008;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001,
        S_SCHED = 7'b000_0010,
        S_FETCH = 7'b000_0100,
        S_LIST = 7'b000_1000,
        S_FRAG = 7'b001_0000,
        S_COPY = 7'b010_0000,
        S_POST = 7'b100_0000
    } fsm_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [2:0] bytes;
    } ram_wr_t;

    typedef struct packed {
        logic start;
        logic [15:0] wire_len;
        logic [15:0] valid_len;
        logic pad;
        logic omit_fcs;
        logic retry;
    } tx_ctl_t;

    typedef struct packed {
        fsm_t fsm;
        logic go;
        logic early_en;
        logic [15:0] ett;
        logic [31:0] cda;
        logic [3:0] evt;
        logic [15:0] result;
        logic wb_ack;
        logic [31:0] wb_dat;
        mem_req_t mem;
        ram_wr_t ram;
        tx_ctl_t tx;
        logic [1:0] idx;
        logic [31:0] tmp0;
        logic [31:0] tmp1;
        logic first;
        logic fin;
        logic wait_requeue;
        logic frag_mode;
        logic frag_fmt;
        logic [5:0] frag_left;
        logic [31:0] list_ptr;
        logic [31:0] buf_addr;
        logic [15:0] buf_len;
        logic [15:0] remaining;
        logic c_active;
        logic c_copied;
        logic c_started;
        logic c_irq;
        logic c_omit;
        logic [31:0] c_desc;
        logic [15:0] c_len;
        logic [15:0] c_loaded;
        logic tx_busy;
        logic s_irq;
        logic [31:0] s_desc;
        logic [15:0] s_len;
        logic done_pend;
        logic [14:0] done_stat;
    } st_t;

    localparam st_t ST_RESET = '{fsm: S_IDLE, default: '0};

endpackage : tx_dma_pkg

// file: ethernet_tx_descriptor_dma.sv
/*
 Transmit descriptor DMA: walks the host descriptor chain, copies frame data
 into the local transmit RAM, starts the transmitter and posts status.
 Assumes word-aligned buffers, a single-beat host memory port and a drain
 unit / MAC on the same clock.
*/
// How it works
// - With queue-go set, read four descriptor dwords at the current descriptor address.
// - Owned descriptor loads next address; otherwise clear queue-go and flag queue-empty.
// - First descriptor length is wire count; copy lesser of remaining and buffer length.
// - Early transmit starts the transmitter once loaded bytes reach the threshold.
// - Copy ends when count exhausted or final bit seen; then start if not started.
// - Short non-final buffer fetches next descriptor, using remaining count, not its length.
// - Final reached with bytes missing: transmit path pads after valid data.
// - Omit-fcs in the last descriptor suppresses the generated CRC.
// - Copy next frame during transmission, wait if done, post then start at once.
// - Transmission ending mid-copy: post at buffer boundary, start if threshold met.
// - Status post writes ownership zero and rewrites the length unchanged.
// - Frame-complete event after transmission when last descriptor requested it.
// - Queue dry raises queue-empty; chain-complete after last transmission, then idle.
// - Fragment mode: indirect bit set, list count first (up to 63), then entries.
// - Fragment copy until length or list exhausted; without early start, wait for copy.
// - Chain-complete once per drained portion, again for appended frames.
// - Halt clears queue-go; begun copies, loaded frames and posts still finish.
// - Host-owned descriptor mid-copy flags queue-empty and waits; never idle mid-copy.
// - Copy reads stall while transmit RAM is full.
// - Starve flags an event, captures result; retry bit resends; DMA keeps running.
`timescale 1ns/1ps
module ethernet_tx_descriptor_dma
    import tx_dma_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output mem_req_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output ram_wr_t ram_o,
    input wire logic ram_full_i,
    output tx_ctl_t tx_o,
    input wire logic tx_done_i,
    input wire logic [14:0] tx_status_i,
    input wire logic tx_starved_i,
    input wire logic [15:0] tx_result_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Bytes a word carries: at most four, bounded by buffer and frame
    function automatic logic [2:0] word_bytes(input logic [15:0] len, input logic [15:0] rem);
        logic [15:0] m;
        m = (len < rem) ? len : rem;
        word_bytes = (m > 16'h0004) ? 3'd4 : m[2:0];
    endfunction : word_bytes

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    st_t st_reg;
    st_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic wr;
        logic [3:0] ev_set;
        logic [3:0] ev_clr;
        logic [2:0] nb;
        logic [31:0] ett_word;
        wr = 1'b0;
        ev_set = 4'h0;
        ev_clr = 4'h0;
        nb = 3'd0;
        ett_word = 32'h0000_0000;
        // Every field except ram.valid, tx.start and tx.retry holds unless a branch below changes it
        st_next = st_reg;
        st_next.ram.valid = 1'b0;
        st_next.tx.start = 1'b0;
        st_next.tx.retry = 1'b0;

        // Transmitter results; the pulse is caught even while software reads
        if (tx_done_i && st_reg.tx_busy) begin
            st_next.done_pend = 1'b1;
            st_next.done_stat = tx_status_i;
        end
        if (tx_starved_i) begin
            ev_set[EVT_STARVED] = 1'b1;
            st_next.result = tx_result_i;
        end

        // Start the transmitter; only one frame is on the wire at a time
        if (st_reg.c_active && !st_reg.c_started && !st_reg.tx_busy && !st_reg.done_pend
            && (st_reg.c_copied || (st_reg.early_en && st_reg.c_loaded >= st_reg.ett))) begin
            st_next.tx.start = 1'b1;
            st_next.tx.wire_len = st_reg.c_len;
            st_next.tx_busy = 1'b1;
            st_next.c_started = 1'b1;
            st_next.s_desc = st_reg.c_desc;
            st_next.s_len = st_reg.c_len;
            st_next.s_irq = st_reg.c_irq;
        end

        // Main sequencer
        case (st_reg.fsm)
            // Wait for software to queue frames
            S_IDLE: begin
                if (st_reg.go) begin
                    st_next.fsm = S_SCHED;
                end
            end

            S_SCHED: begin
                if (st_reg.done_pend) begin
                    st_next.fsm = S_POST;
                end else if (st_reg.c_active && !st_reg.c_copied) begin
                    // Mid-frame: keep copying even after halt
                    if (st_reg.frag_mode) begin
                        st_next.fsm = S_FRAG;
                    end else if (st_reg.go || !st_reg.wait_requeue) begin
                        // Only an unowned descriptor parks a begun frame
                        st_next.fsm = S_FETCH;
                        st_next.first = 1'b0;
                    end
                end else if (st_reg.c_active) begin
                    // Loaded frame waits for the wire
                    if (st_reg.c_started) begin
                        st_next.c_active = 1'b0;
                    end
                end else if (st_reg.go) begin
                    st_next.fsm = S_FETCH;
                    st_next.first = 1'b1;
                end else if (!st_reg.tx_busy) begin
                    ev_set[EVT_CHAIN_DONE] = 1'b1;
                    st_next.fsm = S_IDLE;
                end
            end

            // Word 0 decides ownership and word 3 the next address, once word 3 is read
            S_FETCH: begin
                if (!st_reg.mem.valid) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = st_reg.cda + {28'h000_0000, st_reg.idx, 2'b00};
                end else if (mem_ack_i) begin
                    st_next.mem.valid = 1'b0;
                    st_next.idx = st_reg.idx + 2'd1;
                    case (st_reg.idx)
                        2'd0: st_next.tmp0 = mem_rdata_i;
                        2'd1: st_next.tmp1 = mem_rdata_i;
                        2'd2: st_next.buf_addr = mem_rdata_i;
                        default: begin
                            if (!st_reg.tmp0[DESC_OWN_BIT]) begin
                                st_next.go = 1'b0;
                                st_next.wait_requeue = 1'b1;
                                ev_set[EVT_QUEUE_EMPTY] = 1'b1;
                                st_next.fsm = S_SCHED;
                            end else begin
                                st_next.cda = mem_rdata_i;
                                st_next.wait_requeue = 1'b0;
                                st_next.fin = st_reg.tmp1[DESC_FINAL_BIT];
                                st_next.c_irq = st_reg.tmp1[DESC_IRQ_BIT];
                                st_next.c_omit = st_reg.tmp1[DESC_OMIT_BIT];
                                st_next.frag_mode = st_reg.tmp1[DESC_INDIRECT_BIT];
                                st_next.frag_fmt = st_reg.tmp1[DESC_FORMAT_BIT];
                                st_next.buf_len = st_reg.tmp1[15:0];
                                st_next.list_ptr = st_reg.buf_addr;
                                st_next.fsm = st_reg.tmp1[DESC_INDIRECT_BIT] ? S_LIST : S_COPY;
                                // Length is read only from the frame's first descriptor
                                if (st_reg.first) begin
                                    st_next.c_desc = st_reg.cda;
                                    st_next.c_len = st_reg.tmp0[15:0];
                                    st_next.remaining = st_reg.tmp0[15:0];
                                    st_next.c_loaded = 16'h0000;
                                    st_next.c_active = 1'b1;
                                    st_next.c_copied = 1'b0;
                                    st_next.c_started = 1'b0;
                                end
                            end
                        end
                    endcase
                end
            end

            S_LIST: begin
                if (!st_reg.mem.valid) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = st_reg.list_ptr;
                end else if (mem_ack_i) begin
                    st_next.mem.valid = 1'b0;
                    st_next.idx = 2'd0;
                    st_next.frag_left = mem_rdata_i[FRAG_COUNT_W-1:0];
                    st_next.list_ptr = st_reg.list_ptr + WORD_STEP;
                    st_next.buf_len = 16'h0000;
                    // An empty list completes the frame at once
                    st_next.fsm = (mem_rdata_i[FRAG_COUNT_W-1:0] == 6'd0) ? S_COPY : S_FRAG;
                end
            end

            // Two words per entry, order set by the list format
            S_FRAG: begin
                if (!st_reg.mem.valid) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = st_reg.list_ptr + {28'h000_0000, st_reg.idx, 2'b00};
                end else if (mem_ack_i) begin
                    st_next.mem.valid = 1'b0;
                    if (st_reg.idx == 2'd0) begin
                        st_next.tmp0 = mem_rdata_i;
                        st_next.idx = 2'd1;
                    end else begin
                        // List format picks address-first or length-first entries
                        st_next.buf_addr = st_reg.frag_fmt ? mem_rdata_i : st_reg.tmp0;
                        st_next.buf_len = st_reg.frag_fmt ? st_reg.tmp0[15:0] : mem_rdata_i[15:0];
                        st_next.list_ptr = st_reg.list_ptr + PAIR_STEP;
                        st_next.frag_left = st_reg.frag_left - 6'd1;
                        st_next.idx = 2'd0;
                        st_next.fsm = S_COPY;
                    end
                end
            end

            // Reads wait for a free word of RAM
            S_COPY: begin
                if (st_reg.buf_len == 16'h0000 || st_reg.remaining == 16'h0000) begin
                    // Buffer boundary: the sequencer posts status here if due
                    st_next.fsm = S_SCHED;
                    // Exhausted count or last buffer closes the frame
                    if (st_reg.remaining == 16'h0000
                        || (st_reg.frag_mode ? st_reg.frag_left == 6'd0 : st_reg.fin)) begin
                        st_next.c_copied = 1'b1;
                        st_next.tx.valid_len = st_reg.c_loaded;
                        st_next.tx.pad = st_reg.c_loaded < st_reg.c_len;
                        st_next.tx.omit_fcs = st_reg.c_omit;
                        if (st_next.c_started) begin
                            st_next.s_irq = st_reg.c_irq;
                        end
                    end
                end else if (st_reg.mem.valid) begin
                    if (mem_ack_i) begin
                        st_next.mem.valid = 1'b0;
                        nb = word_bytes(st_reg.buf_len, st_reg.remaining);
                        st_next.ram.valid = 1'b1;
                        st_next.ram.data = mem_rdata_i;
                        st_next.ram.bytes = nb;
                        st_next.buf_addr = st_reg.buf_addr + WORD_STEP;
                        st_next.buf_len = st_reg.buf_len - {13'h0000, nb};
                        st_next.remaining = st_reg.remaining - {13'h0000, nb};
                        st_next.c_loaded = st_reg.c_loaded + {13'h0000, nb};
                    end
                end else if (!ram_full_i) begin
                    // No read is issued unless a word of space is free
                    st_next.mem.valid = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = st_reg.buf_addr;
                end
            end

            S_POST: begin
                if (!st_reg.mem.valid) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.we = 1'b1;
                    st_next.mem.addr = st_reg.s_desc;
                    st_next.mem.wdata = {1'b0, st_reg.done_stat, st_reg.s_len};
                end else if (mem_ack_i) begin
                    st_next.mem.valid = 1'b0;
                    st_next.mem.we = 1'b0;
                    st_next.done_pend = 1'b0;
                    st_next.tx_busy = 1'b0;
                    ev_set[EVT_FRAME_DONE] = st_reg.s_irq;
                    st_next.fsm = S_SCHED;
                end
            end

            default: st_next = ST_RESET;
        endcase

        ////////////////////////////////////////////////////////////////////////
        // Wishbone slave: ack one cycle after the strobe, unmapped reads zero
        st_next.wb_ack = wb_cyc_i & wb_stb_i & ~st_reg.wb_ack;
        // Writes land and read data is latched at the edge that raises ack
        wr = st_next.wb_ack & wb_we_i;
        if (st_next.wb_ack && !wb_we_i) begin
            st_next.wb_dat = 32'h0000_0000;
            case (wb_adr_i)
                REG_CTRL: begin
                    st_next.wb_dat[CTRL_GO_BIT] = st_reg.go;
                    st_next.wb_dat[CTRL_BUSY_BIT] = st_reg.tx_busy;
                    st_next.wb_dat[CTRL_COPY_BIT] = st_reg.c_active;
                    st_next.wb_dat[CTRL_IDLE_BIT] = st_reg.fsm == S_IDLE;
                end
                REG_CDA: st_next.wb_dat = st_reg.cda;
                REG_ETT: begin
                    st_next.wb_dat[15:0] = st_reg.ett;
                    st_next.wb_dat[ETT_EN_BIT] = st_reg.early_en;
                end
                REG_EVT: st_next.wb_dat = {28'h000_0000, st_reg.evt};
                REG_RESULT: st_next.wb_dat = {16'h0000, st_reg.result};
                default: ;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        // Software set beats a same-cycle empty-queue clear
                        if (wb_dat_i[CTRL_GO_BIT]) begin
                            st_next.go = 1'b1;
                            st_next.wait_requeue = 1'b0;
                        end
                        if (wb_dat_i[CTRL_HALT_BIT]) begin
                            st_next.go = 1'b0;
                        end
                        st_next.tx.retry = wb_dat_i[CTRL_RETRY_BIT];
                    end
                end
                REG_CDA: st_next.cda = merge(st_reg.cda, wb_dat_i, wb_sel_i);
                REG_ETT: begin
                    ett_word = merge({15'h0000, st_reg.early_en, st_reg.ett}, wb_dat_i, wb_sel_i);
                    st_next.ett = ett_word[15:0];
                    st_next.early_en = ett_word[ETT_EN_BIT];
                end
                REG_EVT: begin
                    if (wb_sel_i[0]) begin
                        ev_clr = wb_dat_i[3:0];
                    end
                end
                default: ;
            endcase
        end

        // Sticky events: write one to clear, a new event wins
        st_next.evt = (st_reg.evt & ~ev_clr) | ev_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // All outputs come straight from the state register
    assign wb_ack_o = st_reg.wb_ack;
    assign wb_dat_o = st_reg.wb_dat;
    assign mem_o = st_reg.mem;
    assign ram_o = st_reg.ram;
    assign tx_o = st_reg.tx;

endmodule : ethernet_tx_descriptor_dma

// file: tx_dma_asserts.sv
/* Port checker of the transmit descriptor DMA.
 Assumes one clock, synchronous active-high reset, bound to every DMA instance. */
`timescale 1ns/1ps
module tx_dma_asserts
    import tx_dma_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire mem_req_t mem_o,
    input wire logic mem_ack_i,
    input wire ram_wr_t ram_o,
    input wire tx_ctl_t tx_o,
    input wire logic tx_done_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    // Transmitter busy from start to done; a second start would overwrite a live frame
    logic busy_reg;
    always_ff @(posedge clk_i) begin
        busy_reg <= rst_i ? 1'b0 : (tx_done_i ? 1'b0 : (tx_o.start | busy_reg));
    end
    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_MEM_HOLD: assert property (mem_o.valid && !mem_ack_i
        |=> mem_o.valid && $stable(mem_o.addr)) else $error("host request dropped before ack");
    AST_MEM_GAP: assert property (mem_ack_i |=> !mem_o.valid) else $error("no idle gap");
    AST_POST_OWN: assert property (mem_o.valid && mem_o.we |-> !mem_o.wdata[31])
        else $error("post keeps ownership");
    AST_RAM_BYTES: assert property (ram_o.valid |-> ram_o.bytes inside {[1:4]})
        else $error("bad byte count");
    AST_ONE_START: assert property (tx_o.start |-> !busy_reg)
        else $error("start while busy");
    AST_START_PULSE: assert property (tx_o.start |=> !tx_o.start) else $error("long start");
endmodule : tx_dma_asserts
bind ethernet_tx_descriptor_dma tx_dma_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .ram_o(ram_o), .tx_o(tx_o), .tx_done_i(tx_done_i));

// file: tx_dma_host_model.sv
/* Host memory model: 64 words answering the DMA's single-beat requests.
 Assumes byte addresses below 0x100; the bench loads descriptors directly. */
`timescale 1ns/1ps
module tx_dma_host_model
    import tx_dma_pkg::*;
#(
    parameter int SLOW = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire mem_req_t mem_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    // Descriptors hold valid fields before ownership, two-entry chain at least
    logic [31:0] mem [0:63];
    logic [31:0] last_reg;
    int cnt;
    ////////////////////////////////////////////////////////////////////////////
    // Slow answer; idle data shows the inverse so stale reads never look right
    assign rdata_o = ack_o ? mem[mem_i.addr[7:2]] : ~last_reg;
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        if (ack_o) begin
            last_reg <= rdata_o;
            if (mem_i.we) mem[mem_i.addr[7:2]] <= mem_i.wdata;
        end
        if (rst_i || ack_o) cnt <= 0;
        else if (mem_i.valid) begin
            cnt <= cnt + 1;
            ack_o <= (cnt == SLOW);
        end
    end
endmodule : tx_dma_host_model

// file: tb.sv
/* Testbench of the transmit DMA: register rows, one direct frame, starve, halt.
 Assumes the host model and checker files compile first. */
`timescale 1ns/1ps
module tb;
    import tx_dma_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w, r, e;} row_t;
    logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, mem_ack;
    logic tx_done = 0, tx_starved = 0, ram_full = 0;
    logic [7:0] wb_adr = 0;
    logic [31:0] wb_dat = 0, wb_rdat, mem_rdata, q, wlen = 0;
    logic [31:0] rw [0:3];
    logic [15:0] tx_result = 0;
    mem_req_t mem;
    ram_wr_t ram;
    tx_ctl_t tx;
    int fails = 0, n_checks = 0, n, dcnt = 0, nram = 0, starts = 0, retries = 0, tcnt = 0;
    row_t rows [5] = '{'{REG_CDA, 32'h1234_5678, 0, 32'h1234_5678},
        '{REG_ETT, 32'h0001_0010, 0, 32'h0001_0010}, '{REG_EVT, 0, 0, 0},
        '{REG_RESULT, 32'hFFFF_FFFF, 0, 0}, '{8'h14, 32'hFFFF_FFFF, 0, 0}};
    always #20 clk_i = ~clk_i;
    ethernet_tx_descriptor_dma uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(4'hF), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat), .mem_o(mem),
        .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .ram_o(ram), .ram_full_i(ram_full),
        .tx_o(tx), .tx_done_i(tx_done), .tx_status_i(15'h1234), .tx_starved_i(tx_starved),
        .tx_result_i(tx_result));
    tx_dma_host_model host (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem), .ack_o(mem_ack),
        .rdata_o(mem_rdata));
    ////////////////////////////////////////////////////////////////////////////
    // Classic cycle: hold until ack is sampled, then release for one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        if (wb_ack !== 1'b1) fails++;
        q = wb_rdat;
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Transmitter stand-in ends each frame 21 cycles after start; also logs RAM writes
    always @(posedge clk_i) begin
        tx_done <= (dcnt == 1);
        dcnt <= tx.start ? 20 : (dcnt != 0 ? dcnt - 1 : 0);
        if (tx.start) wlen <= {16'h0000, tx.wire_len};
        starts <= starts + int'(tx.start);
        retries <= retries + int'(tx.retry);
        if (ram.valid) rw[nram[1:0]] <= ram.data;
        nram <= nram + int'(ram.valid);
        tcnt <= tcnt + 1;
        if (tcnt == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        host.mem[0] = 32'h8000_000A;
        host.mem[1] = 32'h0007_0008;
        host.mem[2] = 32'h0000_0040;
        host.mem[3] = 32'h0000_0010;
        host.mem[4] = 32'h0000_0000;
        host.mem[16] = 32'h1122_3344;
        host.mem[17] = 32'h5566_7788;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, REG_CTRL, 0);
        chk("ctrl reset", 32'h0000_0020, q);
        foreach (rows[i]) begin
            wb(0, rows[i].a, 0);
            chk("reg reset", rows[i].r, q);
            wb(1, rows[i].a, rows[i].w);
            wb(0, rows[i].a, 0);
            chk("reg readback", rows[i].e, q);
        end
        wb(1, REG_CDA, 0);
        wb(1, REG_ETT, 0);
        ram_full <= 1'b1;
        wb(1, REG_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clk_i);
        chk("ram stall", 0, nram);
        ram_full <= 1'b0;
        for (n = 0; host.mem[0][31] !== 1'b0 && n < 2000; n++) @(posedge clk_i);
        for (n = 0, q = 0; q[CTRL_IDLE_BIT] !== 1'b1 && n < 50; n++) wb(0, REG_CTRL, 0);
        chk("idle", 1, {31'h0, q[CTRL_IDLE_BIT]});
        chk("go", 0, {31'h0, q[CTRL_GO_BIT]});
        chk("post word", {1'b0, 15'h1234, 16'h000A}, host.mem[0]);
        chk("wire len", 32'h0000_000A, wlen);
        chk("pad", 1, {31'h0, tx.pad});
        chk("omit fcs", 1, {31'h0, tx.omit_fcs});
        chk("valid len", 8, {16'h0, tx.valid_len});
        chk("starts", 1, starts);
        chk("ram word0", 32'h1122_3344, rw[0]);
        chk("ram word1", 32'h5566_7788, rw[1]);
        chk("ram count", 2, nram);
        wb(0, REG_CDA, 0);
        chk("cda", 32'h0000_0010, q);
        wb(0, REG_EVT, 0);
        chk("events", 32'h0000_0007, q);
        wb(1, REG_EVT, 32'h0000_000F);
        {tx_starved, tx_result} <= {1'b1, 16'h00A5};
        @(posedge clk_i);
        tx_starved <= 1'b0;
        wb(0, REG_RESULT, 0);
        chk("result", 32'h0000_00A5, q);
        wb(0, REG_EVT, 0);
        chk("starve event", 32'h0000_0008, q);
        wb(1, REG_CTRL, 32'h0000_0004);
        wb(0, REG_EVT, 0);
        chk("retry pulses", 1, retries);
        wb(1, REG_CTRL, 32'h0000_0003);
        wb(0, REG_CTRL, 0);
        chk("halt go", 0, {31'h0, q[CTRL_GO_BIT]});
        report_and_stop();
    end
endmodule : tb
